// File: hdl/sas_alarm_status.sv
// spectral alarm status, worst-case peak and bin registers for three axes
//
// What this block does
// - each axis keeps per-band alarm flags for the chosen sample rate option.
// - band k warning flag at bit 2k+2, critical at 2k+3; one means set.
// - bits 2:0 give most critical band 1 to 6; bit 3 reads zero.
// - all status, peak and bin registers are read-only and reset to zero.
// - each axis stores peak magnitude of its worst-case alarm condition.
// - peak register uses full 16 bits in accelerometer data format.
// - each axis reports worst-case FFT bin 0 to 255 in bits 7:0.
// - bin register bits 15:8 unused; bin is that of the peak alarm.
// - first level is warning, second is critical; critical ranks higher.
// - per axis, two independent 16-bit unsigned warning and critical levels.
// - band limits are 8-bit inclusive bin numbers for the current option.
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.svh"

module sas_axis (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic bin_valid_in,
    input wire logic [7:0] bin_index_in,
    input wire logic [15:0] bin_mag_in,
    input wire logic [15:0] warning_trigger_level_in,
    input wire logic [15:0] critical_trigger_level_in,
    input wire sas_pkg::sas_band_lim_t [5:0] band_lim_in,
    input wire logic commit_in,
    output logic [15:0] status_out,
    output logic [15:0] peak_out,
    output logic [15:0] bin_out
);
    logic [5:0] in_band;
    logic [5:0] hit_w;
    logic [5:0] hit_c;
    logic [11:0] new_flags;
    sas_pkg::sas_sev_t sev;
    logic [2:0] band;
    logic take;
    logic [11:0] acc_flags_r;
    sas_pkg::sas_sev_t acc_sev_r;
    logic [2:0] acc_band_r;
    logic [15:0] acc_peak_r;
    logic [7:0] acc_bin_r;
    logic [15:0] stat_r;
    logic [15:0] peak_r;
    logic [7:0] bin_r;

    // limits are inclusive at both ends; overlapping bands all flag
    always_comb begin
        in_band = '0;
        hit_w = '0;
        hit_c = '0;
        new_flags = '0;
        for (int k = 0; k < 6; k++) begin
            in_band[k] = bin_valid_in && bin_index_in >= band_lim_in[k].lo
                && bin_index_in <= band_lim_in[k].hi;
            hit_w[k] = in_band[k] &&
                bin_mag_in > warning_trigger_level_in;
            hit_c[k] = in_band[k] &&
                bin_mag_in > critical_trigger_level_in;
            new_flags[2*k] = hit_w[k];
            new_flags[2*k+1] = hit_c[k];
        end
    end

    // lowest band number wins among equally severe hits
    always_comb begin
        sev = sas_pkg::SEV_NONE;
        band = 3'h0;
        if (|hit_c) begin
            sev = sas_pkg::SEV_CRIT;
        end else if (|hit_w) begin
            sev = sas_pkg::SEV_WARN;
        end
        for (int k = 5; k >= 0; k--) begin
            if (sev == sas_pkg::SEV_CRIT ? hit_c[k] : hit_w[k]) begin
                band = 3'(k + 1);
            end
        end
        take = (sev != sas_pkg::SEV_NONE) && ((sev > acc_sev_r) ||
            (sev == acc_sev_r && bin_mag_in > acc_peak_r));
    end

    // running result of the record in progress
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_flags_r <= '0;
            acc_sev_r <= sas_pkg::SEV_NONE;
            acc_band_r <= 3'h0;
            acc_peak_r <= 16'h0000;
            acc_bin_r <= 8'h00;
        end else if (commit_in) begin
            acc_flags_r <= '0;
            acc_sev_r <= sas_pkg::SEV_NONE;
            acc_band_r <= 3'h0;
            acc_peak_r <= 16'h0000;
            acc_bin_r <= 8'h00;
        end else if (bin_valid_in) begin
            acc_flags_r <= acc_flags_r | new_flags;
            if (take) begin
                acc_sev_r <= sev;
                acc_band_r <= band;
                acc_peak_r <= bin_mag_in;
                acc_bin_r <= bin_index_in;
            end
        end
    end

    // all three visible words change on the same edge only
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stat_r <= `SAS_RST_VAL;
            peak_r <= `SAS_RST_VAL;
            bin_r <= 8'h00;
        end else if (commit_in) begin
            stat_r <= {acc_flags_r, 1'b0, acc_band_r};
            peak_r <= acc_peak_r;
            bin_r <= acc_bin_r;
        end
    end

    assign status_out = stat_r;
    assign peak_out = peak_r;
    assign bin_out = {8'h00, bin_r};

    logic [1:0] band_pair;
    always_comb begin
        band_pair = 2'b00;
        for (int k = 1; k <= 6; k++) begin
            if (stat_r[2:0] == 3'(k)) begin
                band_pair = stat_r[2*k+3 -: 2];
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    property p_bit3_zero;
        stat_r[`SAS_STAT_UNUSED_BIT] == 1'b0;
    endproperty
    a_bit3_zero: assert property (p_bit3_zero)
        else $error("status bit 3 not zero");

    property p_band_range;
        stat_r[2:0] <= 3'h6;
    endproperty
    a_band_range: assert property (p_band_range)
        else $error("worst band out of range");

    property p_band_flagged;
        stat_r[2:0] != 3'h0 |-> band_pair != 2'b00;
    endproperty
    a_band_flagged: assert property (p_band_flagged)
        else $error("worst band has no flag set");

    property p_commit_flags;
        commit_in |=> stat_r[15:4] == $past(acc_flags_r);
    endproperty
    a_commit_flags: assert property (p_commit_flags)
        else $error("flags not taken at commit");

    property p_hold;
        !commit_in |=> $stable(stat_r) && $stable(peak_r) && $stable(bin_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("results changed without commit");

    property p_bin_upper;
        bin_out[15:8] == 8'h00;
    endproperty
    a_bin_upper: assert property (p_bin_upper)
        else $error("bin upper byte not zero");

    property p_peak_pair;
        commit_in |=> peak_r == $past(acc_peak_r) && bin_r == $past(acc_bin_r);
    endproperty
    a_peak_pair: assert property (p_peak_pair)
        else $error("peak or bin not taken at commit");

    property p_warn_hit;
        bin_valid_in && !commit_in && in_band[0] &&
            bin_mag_in > warning_trigger_level_in |=> acc_flags_r[0];
    endproperty
    a_warn_hit: assert property (p_warn_hit)
        else $error("band 1 warning not flagged");

    property p_crit_rank;
        bin_valid_in && !commit_in && |hit_c |=>
            acc_sev_r == sas_pkg::SEV_CRIT;
    endproperty
    a_crit_rank: assert property (p_crit_rank)
        else $error("critical hit not ranked critical");

    property p_quiet_record;
        commit_in && acc_sev_r == sas_pkg::SEV_NONE |=>
            stat_r[2:0] == 3'h0 && peak_r == 16'h0000;
    endproperty
    a_quiet_record: assert property (p_quiet_record)
        else $error("quiet record left a worst case");

    c_crit_commit: cover property (commit_in &&
        acc_sev_r == sas_pkg::SEV_CRIT);
    c_warn_commit: cover property (commit_in &&
        acc_sev_r == sas_pkg::SEV_WARN);
    c_two_band: cover property (commit_in &&
        acc_flags_r[1] && acc_flags_r[11]);
endmodule // sas_axis

module sas_alarm_status (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic bin_valid_in,
    input wire logic [7:0] bin_index_in,
    input wire sas_pkg::sas_triple_t bin_mag_in,
    input wire sas_pkg::sas_triple_t warning_trigger_level_in,
    input wire sas_pkg::sas_triple_t critical_trigger_level_in,
    input wire sas_pkg::sas_band_lim_t [5:0] band_lim_in,
    input wire logic record_done_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_addr_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out
);
    sas_pkg::sas_triple_t stat;
    sas_pkg::sas_triple_t peak;
    sas_pkg::sas_triple_t bin;
    logic [15:0] rd_data_nxt;
    logic [15:0] rd_data_r;
    logic rd_valid_r;

    sas_axis u_axis_x (
        .clock_in(clock_in), .nrst_in(nrst_in),
        .bin_valid_in(bin_valid_in), .bin_index_in(bin_index_in),
        .bin_mag_in(bin_mag_in.x),
        .warning_trigger_level_in(warning_trigger_level_in.x),
        .critical_trigger_level_in(critical_trigger_level_in.x),
        .band_lim_in(band_lim_in), .commit_in(record_done_in),
        .status_out(stat.x), .peak_out(peak.x), .bin_out(bin.x)
    );
    sas_axis u_axis_y (
        .clock_in(clock_in), .nrst_in(nrst_in),
        .bin_valid_in(bin_valid_in), .bin_index_in(bin_index_in),
        .bin_mag_in(bin_mag_in.y),
        .warning_trigger_level_in(warning_trigger_level_in.y),
        .critical_trigger_level_in(critical_trigger_level_in.y),
        .band_lim_in(band_lim_in), .commit_in(record_done_in),
        .status_out(stat.y), .peak_out(peak.y), .bin_out(bin.y)
    );
    sas_axis u_axis_z (
        .clock_in(clock_in), .nrst_in(nrst_in),
        .bin_valid_in(bin_valid_in), .bin_index_in(bin_index_in),
        .bin_mag_in(bin_mag_in.z),
        .warning_trigger_level_in(warning_trigger_level_in.z),
        .critical_trigger_level_in(critical_trigger_level_in.z),
        .band_lim_in(band_lim_in), .commit_in(record_done_in),
        .status_out(stat.z), .peak_out(peak.z), .bin_out(bin.z)
    );

    // read-only bank: there is no write path at all
    always_comb begin
        unique case (rd_addr_in)
            `SAS_OFF_X_STAT: rd_data_nxt = stat.x;
            `SAS_OFF_Y_STAT: rd_data_nxt = stat.y;
            `SAS_OFF_Z_STAT: rd_data_nxt = stat.z;
            `SAS_OFF_X_PEAK: rd_data_nxt = peak.x;
            `SAS_OFF_Y_PEAK: rd_data_nxt = peak.y;
            `SAS_OFF_Z_PEAK: rd_data_nxt = peak.z;
            `SAS_OFF_X_BIN: rd_data_nxt = bin.x;
            `SAS_OFF_Y_BIN: rd_data_nxt = bin.y;
            `SAS_OFF_Z_BIN: rd_data_nxt = bin.z;
            default: rd_data_nxt = `SAS_UNMAPPED_VAL;
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_r <= `SAS_RST_VAL;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_en_in;
            if (rd_en_in) begin
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign rd_data_out = rd_data_r;
    assign rd_valid_out = rd_valid_r;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    property p_read_status;
        rd_en_in && rd_addr_in == `SAS_OFF_Y_STAT && !record_done_in
            |=> rd_valid_out && rd_data_out == stat.y;
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status read returned wrong word");

    // valid is a one-cycle echo of the strobe, never stretched
    property p_valid_pulse;
        1'b1 |=> rd_valid_out == $past(rd_en_in);
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("read valid not one cycle after strobe");

    c_read_bin: cover property (rd_en_in && rd_addr_in == `SAS_OFF_Z_BIN);
endmodule // sas_alarm_status

`default_nettype wire

// File: hdl/sas_pkg.sv
// types shared by the spectral alarm status bank
package sas_pkg;
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } sas_triple_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } sas_band_lim_t;

    typedef enum logic [1:0] {
        SEV_NONE,
        SEV_WARN,
        SEV_CRIT
    } sas_sev_t;
endpackage

// File: hdl/sas_regs.svh
// register offsets, field positions and reset values of the alarm status bank
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

`define SAS_OFF_X_STAT 8'h40
`define SAS_OFF_Y_STAT 8'h42
`define SAS_OFF_Z_STAT 8'h44
`define SAS_OFF_X_PEAK 8'h46
`define SAS_OFF_Y_PEAK 8'h48
`define SAS_OFF_Z_PEAK 8'h4a
`define SAS_OFF_X_BIN 8'h70
`define SAS_OFF_Y_BIN 8'h72
`define SAS_OFF_Z_BIN 8'h74

`define SAS_STAT_BAND_LSB 0
`define SAS_STAT_BAND_MSB 2
`define SAS_STAT_UNUSED_BIT 3
`define SAS_STAT_FLAG_LSB 4
`define SAS_STAT_FLAG_MSB 15
`define SAS_BIN_MSB 7
`define SAS_RST_VAL 16'h0000
`define SAS_UNMAPPED_VAL 16'h0000

`endif

// File: sim/sas_alarm_status_tb.sv
// self-checking bench for the spectral alarm status bank
`timescale 1ns/1ps
`default_nettype none
module sas_alarm_status_tb;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic bin_valid_in = 1'b0;
    logic [7:0] bin_index_in = 8'h00;
    logic record_done_in = 1'b0;
    sas_pkg::sas_triple_t mag = '0;
    sas_pkg::sas_triple_t warn_lvl = '0;
    sas_pkg::sas_triple_t crit_lvl = '0;
    sas_pkg::sas_band_lim_t [5:0] band_lim = '0;
    logic rd_en;
    logic rd_valid;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic [31:0] lf = 32'hf1e34de1;
    int num_errors = 0;
    int compares = 0;
    int wl[3], cl[3], flags[3], sev[3], pk[3], bn[3], bd[3];

    always #5 clock_in = ~clock_in;

    sas_alarm_status dut (
        .clock_in(clock_in), .nrst_in(nrst_in),
        .bin_valid_in(bin_valid_in), .bin_index_in(bin_index_in),
        .bin_mag_in(mag), .warning_trigger_level_in(warn_lvl),
        .critical_trigger_level_in(crit_lvl), .band_lim_in(band_lim),
        .record_done_in(record_done_in), .rd_en_in(rd_en),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid)
    );

    sas_host host (
        .clock_in(clock_in), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
        .rd_valid_in(rd_valid), .rd_data_in(rd_data)
    );

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04c11db7 : 32'h0);
        return lf;
    endfunction

    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic clr();
        for (int a = 0; a < 3; a++) begin
            flags[a] = 0;
            sev[a] = 0;
            pk[a] = 0;
            bn[a] = 0;
            bd[a] = 0;
        end
    endtask

    // overlapping bands: the lowest band holding the bin is reported
    task automatic model_bin(int idx, int a, int m);
        int s;
        int b0;
        s = (m > cl[a]) ? 2 : (m > wl[a]) ? 1 : 0;
        b0 = 0;
        for (int b = 5; b >= 0; b--) begin
            if (idx >= band_lim[b].lo && idx <= band_lim[b].hi) begin
                b0 = b + 1;
                if (m > wl[a]) flags[a] |= 1 << (2 * b + 4);
                if (m > cl[a]) flags[a] |= 1 << (2 * b + 5);
            end
        end
        if (b0 > 0 && s > 0 &&
            (s > sev[a] || (s == sev[a] && m > pk[a]))) begin
            sev[a] = s;
            pk[a] = m;
            bn[a] = idx;
            bd[a] = b0;
        end
    endtask

    task automatic record(int n);
        logic [31:0] r;
        logic [31:0] r2;
        clr();
        for (int i = 0; i < n; i++) begin
            @(negedge clock_in);
            r = rnd();
            r2 = rnd();
            bin_valid_in = 1'b1;
            bin_index_in = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
            mag = {r[31:16], r2[15:0], r2[31:16]};
            model_bin(bin_index_in, 0, r[31:16]);
            model_bin(bin_index_in, 1, r2[15:0]);
            model_bin(bin_index_in, 2, r2[31:16]);
        end
        // a bin beside the commit is dropped by the design
        @(negedge clock_in);
        mag = 48'(rnd());
        record_done_in = 1'b1;
        @(negedge clock_in);
        record_done_in = 1'b0;
        bin_valid_in = 1'b0;
    endtask

    task automatic check_all();
        logic [15:0] d;
        for (int a = 0; a < 3; a++) begin
            host.rd(8'h40 + 8'(2 * a), d);
            chk("status", d, 16'(flags[a] | bd[a]));
            host.rd(8'h46 + 8'(2 * a), d);
            chk("peak", d, 16'(pk[a]));
            host.rd(8'h70 + 8'(2 * a), d);
            chk("bin", d, 16'(bn[a]));
        end
        host.rd(8'h4c, d);
        chk("unmapped", d, 16'h0000);
    endtask

    task automatic final_report();
        $display("summary: %0d compares, %0d errors", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        for (int b = 0; b < 6; b++) begin
            band_lim[b].lo = 8'(b * 40);
            band_lim[b].hi = 8'(b * 40 + 55);
        end
        repeat (16) @(posedge clock_in);
        @(negedge clock_in);
        nrst_in = 1'b1;
        clr();
        check_all();
        $display("test reset values done");
        for (int t = 0; t < 8; t++) begin
            for (int a = 0; a < 3; a++) begin
                wl[a] = 32'h2000 + (rnd() & 32'h3fff);
                cl[a] = wl[a] + 32'h4000 + (rnd() & 32'h0fff);
            end
            warn_lvl = {16'(wl[0]), 16'(wl[1]), 16'(wl[2])};
            crit_lvl = {16'(cl[0]), 16'(cl[1]), 16'(cl[2])};
            record(2 + int'(rnd() % 32'd30));
            check_all();
            $display("test record %0d done", t);
        end
        @(negedge clock_in);
        nrst_in = 1'b0;
        @(negedge clock_in);
        nrst_in = 1'b1;
        clr();
        check_all();
        $display("test mid-run reset done");
        final_report();
    end

    // whole run is a few hundred cycles
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
endmodule // sas_alarm_status_tb
`default_nettype wire

// File: sim/sas_host.sv
// host-side reader model for the alarm status registers
`timescale 1ns/1ps
`default_nettype none
module sas_host (
    input wire logic clock_in,
    output logic rd_en_out,
    output logic [7:0] rd_addr_out,
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_data_in
);
    initial begin
        rd_en_out = 1'b0;
        rd_addr_out = 8'h00;
    end

    // one-cycle strobe; data returns with the valid pulse
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(negedge clock_in);
        rd_en_out = 1'b1;
        rd_addr_out = a;
        @(negedge clock_in);
        rd_en_out = 1'b0;
        // idle address is scrambled so a stale value cannot pass
        rd_addr_out = ~a;
        while (rd_valid_in !== 1'b1 && n < 4) begin
            @(negedge clock_in);
            n++;
        end
        d = (rd_valid_in === 1'b1) ? rd_data_in : 16'hxxxx;
    endtask
endmodule // sas_host
`default_nettype wire
